// File: hw/sgff_pkg.sv
// Purpose: Shared constants and types of the servo gain/filter core
// Assumes: 25 MHz pclk, 32-bit APB register window
// Notes:   Gains and cutoffs are plain unsigned 16-bit settings

package sgff_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 40;
  localparam int CTRL_PERIOD_NS = 62500;
  localparam int TICK_CYC       = CTRL_PERIOD_NS / CLK_PERIOD_NS;
  // Filter coefficient per Hz: 2*pi*Tctrl*2^16
  localparam int LPF_K = int'(6.2832 * CTRL_PERIOD_NS * 65.536 / 1.0e6);

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TUNE = 8'h04;
  localparam logic [7:0] OFS_G1A  = 8'h08;
  localparam logic [7:0] OFS_G1B  = 8'h0c;
  localparam logic [7:0] OFS_G2A  = 8'h10;
  localparam logic [7:0] OFS_G2B  = 8'h14;
  localparam logic [7:0] OFS_FBF  = 8'h18;
  localparam logic [7:0] OFS_FFC  = 8'h1c;
  localparam logic [7:0] OFS_STAT = 8'h20;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SW_LSB   = 4;
  localparam int CTRL_MT_BIT   = 8;
  localparam int TUNE_J_LSB    = 16;
  localparam int HI_LSB        = 16;
  localparam int FFC_PCT_LSB   = 4;
  localparam int DI_GAIN_BIT   = 26;

  // ---------------------------------------------------------------
  // Limits and reset values
  // ---------------------------------------------------------------
  localparam logic [5:0]  STIFF_MAX   = 6'h29;
  localparam logic [15:0] IT_OFF      = 16'hc800;
  localparam logic [15:0] FC_BYPASS   = 16'h1f40;
  localparam logic [16:0] J_UNITY     = 17'h00064;
  localparam logic [11:0] PCT_FULL    = 12'h3e8;
  localparam logic [5:0]  RST_STIFF   = 6'h1f;
  localparam logic [15:0] RST_GAIN    = 16'h0100;
  localparam logic [15:0] RST_ITIME   = 16'h07d0;
  localparam logic [15:0] RST_CUTOFF  = 16'h1f40;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_POS = 2'b00, MODE_SPD = 2'b01, MODE_TRQ = 2'b10, MODE_RSV = 2'b11
  } sgff_mode_t;

  typedef enum logic [1:0] {
    SW_FIXED = 2'b00, SW_DI = 2'b01, SW_DI_PPI = 2'b10, SW_RSV = 2'b11
  } sgff_sw_t;

  typedef enum logic [1:0] {
    FF_NONE = 2'b00, FF_POSREF = 2'b01, FF_MODEL = 2'b10, FF_RSV = 2'b11
  } sgff_ffsrc_t;

  typedef struct packed {
    logic [15:0] pos_gain;
    logic [15:0] speed_gain;
    logic [15:0] integ_time;
    logic [15:0] torque_cut;
  } sgff_gain_t;
endpackage : sgff_pkg

// File: hw/sgff_lpf.sv
// Purpose: First-order low-pass stage, updated once per control cycle
// Assumes: coef = 2*pi*fc*Tctrl scaled by 2^16
// Notes:   bypass passes the input straight through

`timescale 1ns/1ps
module sgff_lpf #(
  parameter int W = 16
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                en,
  input  wire logic                bypass,
  input  wire logic [15:0]         coef,
  input  wire logic signed [W-1:0] x,
  output logic signed [W-1:0]      y_r
);
  logic signed [W+15:0] acc_r;
  wire  signed [W+16:0] diff = $signed({x, 16'h0000}) - acc_r;
  wire  signed [W+33:0] prod = diff * $signed({1'b0, coef});
  wire  signed [W+33:0] step = prod >>> 16;
  wire  signed [W+15:0] acc_nxt = acc_r + step[W+15:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= '0;
      y_r   <= '0;
    end else if (en) begin
      acc_r <= bypass ? $signed({x, 16'h0000}) : acc_nxt;
      y_r   <= bypass ? x : acc_nxt[W+15:16];
    end
  end

  property p_bypass;
    @(posedge clk) disable iff (!rst_n)
    en && bypass |=> y_r == $past(x);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not through");
endmodule : sgff_lpf

// File: hw/sgff_hist.sv
// Purpose: Sample history for the moving average of speed feedback
// Assumes: one write port, one read port, read data registered
// Notes:   Contents are not reset; the caller tracks fill level

`timescale 1ns/1ps
module sgff_hist #(
  parameter int W  = 16,
  parameter int AW = 4
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic [W-1:0]       rdata_r
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem[raddr];
    end
  end
endmodule : sgff_hist

// File: hw/sgff_core.sv
// Purpose: Two-set gain control, torque/feedback filters, speed feedforward
// Assumes: APB slave, zero wait states, inputs synchronous to pclk
// Notes:   All loop arithmetic advances once per control tick
//
// Notes on behaviour
// - Stiffness 0 weakest, 41 strongest gains
// - Inertia ratio 1.00 doubles speed gain
// - First set members applied together
// - Second set members applied together
// - Integral time 512.00 ms disables integration
// - First torque filter after reset, set one
// - Second torque filter with second set
// - Feedback cutoff 8000 Hz passes unfiltered
// - Nonzero average count overrides low-pass
// - Feedforward source 0 none, 1, 2
// - Model source only position mode, enabled
// - Position mode adds scaled feedforward
// - Feedforward smoothed before scaling
// - Control bit 26 selects second set, not in torque mode

`timescale 1ns/1ps
module sgff_core
  import sgff_pkg::*;
#(
  parameter int W   = 16,
  parameter int AW  = 4,
  parameter int DIV = TICK_CYC
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [31:0]         digital_output_control_word,
  input  wire logic signed [W-1:0] pos_ref_speed_in,
  input  wire logic signed [W-1:0] model_speed_ff_in,
  input  wire logic signed [W-1:0] speed_cmd_in,
  input  wire logic signed [W-1:0] speed_fb_raw_in,
  output logic signed [W-1:0]      speed_ref_out,
  output logic signed [W-1:0]      speed_fb_out,
  output logic signed [W-1:0]      torque_ref_out,
  output logic [15:0]              pos_gain_out,
  output logic                     gain_set2_out
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic signed [W-1:0] sat(input logic signed [39:0] v);
    logic signed [39:0] hi;
    logic signed [39:0] lo;
    hi = 40'sd1 <<< (W-1);
    lo = -hi;
    hi = hi - 40'sd1;
    if (v > hi)      sat = hi[W-1:0];
    else if (v < lo) sat = lo[W-1:0];
    else             sat = v[W-1:0];
  endfunction : sat

  function automatic logic [15:0] coef_of(input logic [15:0] fc);
    logic [31:0] c;
    c = fc * 32'(LPF_K);
    coef_of = (|c[31:16]) ? 16'hffff : c[15:0];
  endfunction : coef_of

  function automatic logic [3:0] msb_of(input logic [15:0] v);
    msb_of = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) msb_of = 4'(i);
    end
  endfunction : msb_of

  // Stiffness scales a base gain: level 31 leaves it unchanged
  function automatic logic [15:0] stiff_scale(input logic [15:0] g,
                                              input logic [5:0]  s);
    logic [22:0] m;
    m = g * (7'({1'b0, s}) + 7'h01);
    stiff_scale = (|m[22:21]) ? 16'hffff : m[20:5];
  endfunction : stiff_scale

  // ---------------------------------------------------------------
  // Control tick
  // ---------------------------------------------------------------
  logic [$clog2(DIV)-1:0] tick_cnt_r;
  logic                   tick;
  assign tick = (tick_cnt_r == ($clog2(DIV))'(DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_cnt_r <= '0;
    else          tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  sgff_mode_t  mode_r;
  sgff_sw_t    sw_r;
  sgff_ffsrc_t ff_src_r;
  sgff_gain_t  set1_r, set2cfg_r, active_r;
  logic        mt_en_r, set2_r;
  logic [5:0]  stiff_r;
  logic [15:0] inertia_r, fb_cut_r, ff_cut_r, kv_r;
  logic [AW-1:0] avg_n_r;
  logic [11:0] ff_pct_r;
  logic        integ_off;
  logic        mt_eff;

  wire setup  = psel & ~penable;
  wire wr     = psel & penable & pwrite & pready;
  wire h_ctrl = paddr == OFS_CTRL;
  wire h_tune = paddr == OFS_TUNE;
  wire h_g1a  = paddr == OFS_G1A;
  wire h_g1b  = paddr == OFS_G1B;
  wire h_g2a  = paddr == OFS_G2A;
  wire h_g2b  = paddr == OFS_G2B;
  wire h_fbf  = paddr == OFS_FBF;
  wire h_ffc  = paddr == OFS_FFC;
  wire h_stat = paddr == OFS_STAT;
  wire mapped = h_ctrl | h_tune | h_g1a | h_g1b | h_g2a | h_g2b |
                h_fbf | h_ffc | h_stat;
  wire [5:0] stiff_wr = (pwdata[5:0] > STIFF_MAX) ? STIFF_MAX : pwdata[5:0];

  wire [31:0] rd_mux =
    h_ctrl ? {23'h0, mt_en_r, 2'b00, sw_r, 2'b00, mode_r} :
    h_tune ? {inertia_r, 10'h0, stiff_r} :
    h_g1a  ? {set1_r.speed_gain, set1_r.pos_gain} :
    h_g1b  ? {set1_r.torque_cut, set1_r.integ_time} :
    h_g2a  ? {set2cfg_r.speed_gain, set2cfg_r.pos_gain} :
    h_g2b  ? {set2cfg_r.torque_cut, set2cfg_r.integ_time} :
    h_fbf  ? {(16-AW)'(0), avg_n_r, fb_cut_r} :
    h_ffc  ? {ff_cut_r, ff_pct_r, 2'b00, ff_src_r} :
    h_stat ? {28'h0, mt_eff, integ_off, set2_r, set2_r} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= setup ? rd_mux : prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r  <= MODE_POS;
      sw_r    <= SW_FIXED;
      mt_en_r <= 1'b0;
      stiff_r <= RST_STIFF;
      inertia_r <= 16'h0;
    end else if (wr && h_ctrl) begin
      mode_r  <= sgff_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
      sw_r    <= sgff_sw_t'(pwdata[CTRL_SW_LSB +: 2]);
      mt_en_r <= pwdata[CTRL_MT_BIT];
    end else if (wr && h_tune) begin
      stiff_r   <= stiff_wr;
      inertia_r <= pwdata[TUNE_J_LSB +: 16];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set1_r    <= {RST_GAIN, RST_GAIN, RST_ITIME, RST_CUTOFF};
      set2cfg_r <= {RST_GAIN, RST_GAIN, RST_ITIME, RST_CUTOFF};
    end else if (wr) begin
      if (h_g1a) {set1_r.speed_gain, set1_r.pos_gain} <= pwdata;
      if (h_g1b) {set1_r.torque_cut, set1_r.integ_time} <= pwdata;
      if (h_g2a) {set2cfg_r.speed_gain, set2cfg_r.pos_gain} <= pwdata;
      if (h_g2b) {set2cfg_r.torque_cut, set2cfg_r.integ_time} <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_cut_r <= RST_CUTOFF;
      avg_n_r  <= '0;
      ff_src_r <= FF_NONE;
      ff_pct_r <= 12'h0;
      ff_cut_r <= RST_CUTOFF;
    end else if (wr && h_fbf) begin
      fb_cut_r <= pwdata[15:0];
      avg_n_r  <= pwdata[HI_LSB +: AW];
    end else if (wr && h_ffc) begin
      ff_src_r <= sgff_ffsrc_t'(pwdata[1:0]);
      ff_pct_r <= pwdata[FFC_PCT_LSB +: 12];
      ff_cut_r <= pwdata[HI_LSB +: 16];
    end
  end

  // ---------------------------------------------------------------
  // Gain set selection
  // ---------------------------------------------------------------
  wire di_sw   = (sw_r == SW_DI) || (sw_r == SW_DI_PPI);
  wire sel2    = di_sw && digital_output_control_word[DI_GAIN_BIT] &&
                 (mode_r != MODE_TRQ);
  wire sgff_gain_t set2_eff = (sw_r == SW_DI_PPI) ?
       {set2cfg_r[63:32], IT_OFF, set2cfg_r.torque_cut} : set2cfg_r;
  wire sgff_gain_t set_nxt = sel2 ? set2_eff : set1_r;
  wire [15:0] kv_st  = stiff_scale(set_nxt.speed_gain, stiff_r);
  wire [34:0] kv_j   = {1'b0, kv_st} * (inertia_r + J_UNITY);
  wire [34:0] kv_q   = kv_j / 35'(J_UNITY);
  wire [15:0] kv_nxt = (|kv_q[34:16]) ? 16'hffff : kv_q[15:0];

  // Swap only at the tick so loop terms never mix two sets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_r     <= {RST_GAIN, RST_GAIN, RST_ITIME, RST_CUTOFF};
      set2_r       <= 1'b0;
      kv_r         <= 16'h0;
      pos_gain_out <= 16'h0;
    end else if (tick) begin
      active_r     <= set_nxt;
      set2_r       <= sel2;
      kv_r         <= kv_nxt;
      pos_gain_out <= stiff_scale(set_nxt.pos_gain, stiff_r);
    end
  end
  assign gain_set2_out = set2_r;

  // ---------------------------------------------------------------
  // Speed loop (PI); accumulator wraps only after extreme windup
  // ---------------------------------------------------------------
  logic signed [39:0] integ_r;
  wire signed [W:0]    err = speed_ref_out - speed_fb_out;
  wire signed [W+16:0] p   = $signed({1'b0, kv_r}) * err;
  wire signed [W+16:0] pi  = p >>> msb_of(active_r.integ_time);
  wire signed [39:0]   trq = 40'(p) + integ_r;
  wire signed [W-1:0]  trq_raw = sat(trq >>> 10);
  assign integ_off = active_r.integ_time == IT_OFF;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)  integ_r <= 40'sh0;
    else if (tick) integ_r <= integ_off ? 40'sh0 : integ_r + 40'(pi);
  end

  // ---------------------------------------------------------------
  // Torque reference filters
  // ---------------------------------------------------------------
  logic signed [W-1:0] tf1_y, tf2_y, fb_y, ff_y;

  sgff_lpf #(.W(W)) u_tf1 (
    .clk(pclk), .rst_n(presetn), .en(tick),
    .bypass(set1_r.torque_cut >= FC_BYPASS),
    .coef(coef_of(set1_r.torque_cut)), .x(trq_raw), .y_r(tf1_y));

  sgff_lpf #(.W(W)) u_tf2 (
    .clk(pclk), .rst_n(presetn), .en(tick),
    .bypass(set2cfg_r.torque_cut >= FC_BYPASS),
    .coef(coef_of(set2cfg_r.torque_cut)), .x(trq_raw), .y_r(tf2_y));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)  torque_ref_out <= '0;
    else if (tick) torque_ref_out <= set2_r ? tf2_y : tf1_y;
  end

  // ---------------------------------------------------------------
  // Speed feedback: low-pass or moving average
  // ---------------------------------------------------------------
  logic [AW-1:0]  wptr_r;
  logic [AW:0]    fill_r;
  logic signed [W+AW:0] sum_r;
  logic signed [W-1:0]  avg_r, old_rd;
  wire avg_on  = avg_n_r != '0;
  wire avg_clr = wr && h_fbf;
  wire signed [W-1:0] old = (fill_r >= {1'b0, avg_n_r}) ? old_rd : '0;
  wire signed [W+AW:0] sum_nxt = sum_r + speed_fb_raw_in - old;
  wire signed [W+AW:0] avg_q = sum_nxt / $signed({1'b0, avg_on ? avg_n_r
                                         : (AW)'(1)});

  sgff_lpf #(.W(W)) u_fb (
    .clk(pclk), .rst_n(presetn), .en(tick),
    .bypass(fb_cut_r >= FC_BYPASS),
    .coef(coef_of(fb_cut_r)), .x(speed_fb_raw_in), .y_r(fb_y));

  sgff_hist #(.W(W), .AW(AW)) u_hist (
    .clk(pclk), .rst_n(presetn), .we(tick && avg_on), .waddr(wptr_r),
    .wdata(speed_fb_raw_in), .raddr(wptr_r - avg_n_r), .rdata_r(old_rd));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_r <= '0;
      fill_r <= '0;
      sum_r  <= '0;
      avg_r  <= '0;
    end else if (avg_clr) begin
      fill_r <= '0;
      sum_r  <= '0;
    end else if (tick && avg_on) begin
      wptr_r <= wptr_r + 1'b1;
      fill_r <= fill_r[AW] ? fill_r : fill_r + 1'b1;
      sum_r  <= sum_nxt;
      avg_r  <= avg_q[W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)  speed_fb_out <= '0;
    else if (tick) speed_fb_out <= avg_on ? avg_r : fb_y;
  end

  // ---------------------------------------------------------------
  // Speed feedforward; cutoff should be fixed before raising percent
  // ---------------------------------------------------------------
  assign mt_eff = (mode_r == MODE_POS) && mt_en_r;
  wire signed [W-1:0] ff_sel =
    (ff_src_r == FF_POSREF)          ? pos_ref_speed_in :
    (ff_src_r == FF_MODEL && mt_eff) ? model_speed_ff_in : '0;

  sgff_lpf #(.W(W)) u_ff (
    .clk(pclk), .rst_n(presetn), .en(tick),
    .bypass(ff_cut_r >= FC_BYPASS),
    .coef(coef_of(ff_cut_r)), .x(ff_sel), .y_r(ff_y));

  wire signed [W+12:0] ff_prod = ff_y * $signed({1'b0, ff_pct_r});
  wire signed [W+12:0] ff_scl  = ff_prod / $signed({1'b0, PCT_FULL});
  wire signed [39:0]   ref_sum = 40'(speed_cmd_in) + 40'(ff_scl);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)  speed_ref_out <= '0;
    else if (tick) speed_ref_out <= (mode_r == MODE_POS) ?
                                    sat(ref_sum) : speed_cmd_in;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && pready; endsequence

  property p_apb; s_setup |=> pready ##0 (pslverr == !$past(mapped));
  endproperty
  a_apb: assert property (p_apb) else $error("apb answer wrong");
  property p_stiff; s_access ##0 (pwrite && h_tune && pwdata[5:0] > 6'h29)
    |=> stiff_r == 6'h29; endproperty
  a_stiff: assert property (p_stiff) else $error("stiffness not clamped");
  property p_hold; !tick |=> $stable(set2_r) && $stable(active_r);
  endproperty
  a_hold: assert property (p_hold) else $error("set changed off tick");
  property p_sel1; tick && !sel2 |=> active_r == $past(set1_r); endproperty
  a_sel1: assert property (p_sel1) else $error("first set not applied");
  property p_di; tick && (sw_r == SW_DI) && mode_r == MODE_POS &&
    digital_output_control_word[26] |=> set2_r &&
    active_r == $past(set2cfg_r); endproperty
  a_di: assert property (p_di) else $error("second set not taken");
  property p_ioff; tick && integ_off |=> integ_r == 0; endproperty
  a_ioff: assert property (p_ioff) else $error("integral not off");
  property p_tsel; tick |=> torque_ref_out ==
    $past(set2_r ? tf2_y : tf1_y); endproperty
  a_tsel: assert property (p_tsel) else $error("torque filter wrong");
  property p_avg; tick && avg_on |=> speed_fb_out == $past(avg_r);
  endproperty
  a_avg: assert property (p_avg) else $error("average not used");
  property p_mt; ff_src_r == FF_MODEL && !mt_eff |-> ff_sel == 0;
  endproperty
  a_mt: assert property (p_mt) else $error("model feedforward leak");
  property p_nopos; tick && mode_r != MODE_POS |=>
    speed_ref_out == $past(speed_cmd_in); endproperty
  a_nopos: assert property (p_nopos) else $error("feedforward outside pos");
endmodule : sgff_core

// File: tb/sgff_feed_model.sv
// Purpose: Encoder feedback and reference source beside the loop core
// Assumes: bench sets the targets; values move on rising pclk only
// Notes:   Model source is the negated reference, to tell sources apart

`timescale 1ns/1ps
module sgff_feed_model
  import sgff_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic signed [15:0] ref_set,
  input  wire logic signed [15:0] fb_set,
  output logic signed [15:0]      pos_ref_r,
  output logic signed [15:0]      model_ff_r,
  output logic signed [15:0]      fb_raw_r
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_ref_r  <= 16'sh0000;
      model_ff_r <= 16'sh0000;
      fb_raw_r   <= 16'sh0000;
    end else begin
      pos_ref_r  <= ref_set;
      model_ff_r <= -ref_set;
      fb_raw_r   <= fb_set;
    end
  end
endmodule : sgff_feed_model

// File: tb/tb.sv
// Purpose: Self-checking bench for the gain and filter core
// Assumes: zero-wait APB slave, control tick shortened to D cycles
// Notes:   Waits are whole ticks so outputs are read while settled

`timescale 1ns/1ps
module tb import sgff_pkg::*;;
  localparam int D = 4;
  logic               pclk    = 1'b0;
  logic               presetn = 1'b0;
  logic               psel    = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite  = 1'b0;
  logic [7:0]         paddr   = 8'h00;
  logic [31:0]        pwdata  = 32'h0;
  logic [31:0]        dio     = 32'h0;
  logic signed [15:0] cmd     = 16'sh0000;
  logic signed [15:0] ref_set = 16'sh0000;
  logic signed [15:0] fb_set  = 16'sh0000;
  logic signed [15:0] pref, mff, fbr, sref, sfb, tref;
  logic [31:0]        prdata, rd;
  logic [15:0]        pgain;
  logic               pready, pslverr, err, set2;
  int                 n_errors = 0;
  int                 checks   = 0;

  always #20 pclk = ~pclk;

  sgff_feed_model feed (.pclk(pclk), .presetn(presetn), .ref_set(ref_set),
    .fb_set(fb_set), .pos_ref_r(pref), .model_ff_r(mff), .fb_raw_r(fbr));

  sgff_core #(.W(16), .AW(4), .DIV(D)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .digital_output_control_word(dio), .pos_ref_speed_in(pref),
    .model_speed_ff_in(mff), .speed_cmd_in(cmd), .speed_fb_raw_in(fbr),
    .speed_ref_out(sref), .speed_fb_out(sfb), .torque_ref_out(tref),
    .pos_gain_out(pgain), .gain_set2_out(set2));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic give_verdict;
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Waits on pready however long; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  // Tick period is D cycles, set here through DIV, so a whole-tick wait is exact
  task automatic ticks(input int n);
    repeat (n * D) @(posedge pclk);
    #1;
  endtask : ticks

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFS_TUNE, 32'h0000001f);
    rdc(OFS_G1A, 32'h01000100);
    rdc(OFS_G1B, 32'h1f4007d0);
    rdc(OFS_STAT, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    ticks(2);
    chk(pgain, 32'h0100);
    apb(1'b1, OFS_TUNE, 32'h00000032);
    rdc(OFS_TUNE, 32'h00000029);
    ticks(2);
    chk(pgain, 32'h0150);
    apb(1'b1, OFS_TUNE, 32'h0);
    ticks(2);
    chk(pgain, 32'h0008);
    apb(1'b1, OFS_TUNE, 32'h0064001f);
    apb(1'b1, OFS_G2A, 32'h01000200);
    apb(1'b1, OFS_CTRL, 32'h10);
    ticks(2);
    chk({31'h0, set2}, 32'h0);
    @(posedge pclk);
    dio <= 32'h04000000;
    ticks(2);
    chk({31'h0, set2}, 32'h1);
    chk(pgain, 32'h0200);
    rdc(OFS_STAT, 32'h3);
    apb(1'b1, OFS_CTRL, 32'h12);
    ticks(2);
    chk({31'h0, set2}, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h11);
    ticks(2);
    chk({31'h0, set2}, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h20);
    ticks(2);
    rdc(OFS_STAT, 32'h7);
    dio <= 32'h0;
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_G1B, 32'h1f40c800);
    ticks(2);
    chk({31'h0, set2}, 32'h0);
    rdc(OFS_STAT, 32'h4);
    apb(1'b1, OFS_G1B, 32'h1f4007d0);
    // Feedback path
    fb_set <= 16'sh03e8;
    ticks(3);
    chk(sfb, 32'h03e8);
    ticks(1);
    chk(tref, 32'hfffffe0c);
    apb(1'b1, OFS_FBF, 32'h00000001);
    fb_set <= 16'sh0300;
    ticks(3);
    chk({31'h0, sfb == 16'sh0300}, 32'h0);
    @(posedge pclk);
    fb_set <= 16'sh0200;
    ticks(1);
    apb(1'b1, OFS_FBF, 32'h00010001);
    ticks(6);
    chk(sfb, 32'h0200);
    // Feedforward: cutoff fixed first, percentage raised from 0
    @(posedge pclk);
    cmd     <= 16'sh0064;
    ref_set <= 16'sh00c8;
    ticks(3);
    chk(sref, 32'h0064);
    apb(1'b1, OFS_FFC, 32'h1f400001);
    ticks(3);
    chk(sref, 32'h0064);
    apb(1'b1, OFS_FFC, 32'h1f401f41);
    ticks(3);
    chk(sref, 32'h00c8);
    apb(1'b1, OFS_FFC, 32'h1f403e81);
    ticks(3);
    chk(sref, 32'h012c);
    apb(1'b1, OFS_FFC, 32'h1f403e82);
    ticks(3);
    chk(sref, 32'h0064);
    apb(1'b1, OFS_CTRL, 32'h100);
    ticks(3);
    chk(sref, 32'hffffff9c);
    apb(1'b1, OFS_CTRL, 32'h101);
    ticks(3);
    chk(sref, 32'h0064);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_FFC, 32'h00013e81);
    ref_set <= 16'sh03e8;
    ticks(3);
    chk({31'h0, sref == 16'sh044c}, 32'h0);
    give_verdict();
  end

  initial begin
    #1ms;
    n_errors++;
    give_verdict();
  end
endmodule : tb
